// ---- rtl/vtc_pkg.sv ----
// constants and types of the vector type converter
// Overview of operation
// [RQ1] Each lane is converted independently to signed or unsigned arithmetic.
// [RQ2] Several samples per period arrive in parallel, lane count set at build time.
// [RQ3] Output is Boolean, fixed-point or floating-point.
// [RQ4] Fixed output uses configured bit count and binary point, bit zero is LSB.
// [RQ5] Float output supports single, double or custom exponent and fraction widths.
// [RQ6] Truncate drops all fraction bits below the least representable bit.
// [RQ7] Symmetric round goes to nearest, midpoints away from zero.
// [RQ8] Convergent round goes to nearest, midpoints to even kept LSB.
// [RQ9] Saturate clamps out-of-range results to most positive or negative value.
// [RQ10] Wrap drops bits above the most significant representable bit.
// [RQ11] Flag-as-error overflow mode builds the same hardware as wrap.
// [RQ12] Truncate and wrap are pure bit selection; rounding and saturation add logic.
// [RQ13] Enable low freezes state until enable returns or reset; upstream drives it. Here the output fifo keeps draining while en is low.
// [RQ14] Output is delayed by the configured latency in sample periods; here the output fifo adds one more cycle.
// [RQ15] Without max pipelining: one core output register, then a register chain.
// [RQ16] With max pipelining: latency placed inside the core up to its maximum.
// [RQ17] Extra fraction bits fill with zero; integer bits extend by sign or zero.
package vtc_pkg;
    // datapath shape
    localparam int LANES_PER_PERIOD = 4;
    localparam int IN_W = 16;
    localparam int IN_BP = 8;
    localparam int OUT_BITS = 12;
    localparam int OUT_BP = 4;
    localparam int DROP = (IN_BP > OUT_BP) ? IN_BP - OUT_BP : 0;
    localparam int GROW = (OUT_BP > IN_BP) ? OUT_BP - IN_BP : 0;
    localparam int WIDE_W = IN_W + OUT_BITS + 2;
    localparam logic [WIDE_W-1:0] DROP_MASK = (WIDE_W'(1) << DROP) - WIDE_W'(1);
    localparam logic [WIDE_W-1:0] HALF_VAL = (DROP > 0) ? WIDE_W'(1) << (DROP - 1) : '0;
    // floating-point formats
    localparam int FP_SINGLE = 0;
    localparam int FP_DOUBLE = 1;
    localparam int FP_CUSTOM = 2;
    localparam int FP_SEL = FP_SINGLE;
    localparam int CUST_EXP_W = 6;
    localparam int CUST_FRAC_W = 13;
    localparam int FP_EXP_W = (FP_SEL == FP_SINGLE) ? 8 : (FP_SEL == FP_DOUBLE) ? 11 : CUST_EXP_W;
    localparam int FP_FRAC_W = (FP_SEL == FP_SINGLE) ? 23 :
                               (FP_SEL == FP_DOUBLE) ? 52 : CUST_FRAC_W;
    localparam int FP_W = 1 + FP_EXP_W + FP_FRAC_W;
    localparam int FP_BIAS = (1 << (FP_EXP_W - 1)) - 1;
    localparam int LANE_OUT_W = (FP_W > OUT_BITS) ? FP_W : OUT_BITS;
    // latency and pipelining
    localparam int LATENCY = 3;
    localparam bit PIPE_MAX = 1'b1;
    localparam int CORE_MAX_LAT = 2;
    localparam int MID_STAGE = (PIPE_MAX && LATENCY >= CORE_MAX_LAT) ? 1 : 0;
    localparam int NREG = (LATENCY > 0) ? LATENCY - MID_STAGE : 0;
    localparam int FIFO_DEPTH = 16;
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;
    // register map
    localparam logic [5:0] CTRL_IDX = 6'h00;
    localparam logic [5:0] STATUS_IDX = 6'h01;
    localparam logic [5:0] CONFIG_IDX = 6'h02;
    localparam int CTRL_TYPE_POS = 0;
    localparam int CTRL_QUANT_POS = 2;
    localparam int CTRL_OVF_POS = 4;
    localparam int CTRL_INSGN_POS = 6;
    localparam int CTRL_OUTSGN_POS = 7;
    localparam logic [7:0] CTRL_RESET = 8'hC1;
    localparam int ST_LVL_POS = 0;
    localparam int ST_FULL_POS = 8;
    localparam int ST_EMPTY_POS = 9;
    localparam int ST_EN_POS = 10;
    localparam int ST_BUSY_POS = 11;
    localparam int CFG_LAT_POS = 8;
    localparam int CFG_PIPE_POS = 16;
    localparam int CFG_FP_POS = 17;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        VTC_OUT_BOOL = 2'h0,
        VTC_OUT_FIXED = 2'h1,
        VTC_OUT_FLOAT = 2'h2
    } vtc_out_t;
    typedef enum logic [1:0] {
        VTC_Q_TRUNC = 2'h0,
        VTC_Q_SYM = 2'h1,
        VTC_Q_CONV = 2'h2
    } vtc_quant_t;
    typedef enum logic [1:0] {
        VTC_OV_SAT = 2'h0,
        VTC_OV_WRAP = 2'h1,
        VTC_OV_FLAG = 2'h2
    } vtc_ovf_t;
endpackage

// ---- rtl/vtc_top.sv ----
// vector type converter with output fifo and axi4-lite control
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps

module vtc_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // fill side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    // drain side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data,
    // fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign wr_ready = ce && (cnt_r != (AW+1)'(DEPTH));
    assign rd_valid = ce && (cnt_r != '0);
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;
    assign rd_data = mem[rp_r];
    assign level = cnt_r;

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wp_r] <= wr_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= rp_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module vtc_top import vtc_pkg::*; (
    // clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // sample input
    input wire logic en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [LANES_PER_PERIOD*IN_W-1:0] in_data,
    // converted output
    output logic out_valid,
    input wire logic out_ready,
    output logic [LANES_PER_PERIOD*LANE_OUT_W-1:0] out_data,
    // axi4-lite write
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int PKT_W = LANES_PER_PERIOD * LANE_OUT_W;
    localparam int RAW_W = LANES_PER_PERIOD * IN_W;
    localparam int RND_W = LANES_PER_PERIOD * WIDE_W;
    localparam int NARR = (NREG > 0) ? NREG : 1;

    logic [7:0] ctrl_r;
    vtc_out_t out_type;
    vtc_quant_t quant;
    vtc_ovf_t ovf;
    logic in_sgn;
    logic out_sgn;
    logic adv;
    logic fifo_wr_ready;
    logic fifo_wr_valid;
    logic [PKT_W-1:0] fifo_wr_data;
    logic [LVL_W-1:0] fifo_level;
    logic [RND_W-1:0] rnd_comb;
    logic [RAW_W-1:0] b_raw;
    logic [RND_W-1:0] b_rnd;
    logic b_vld;
    logic [PKT_W-1:0] b_out;
    logic busy;

    assign out_type = vtc_out_t'(ctrl_r[CTRL_TYPE_POS +: 2]);
    assign quant = vtc_quant_t'(ctrl_r[CTRL_QUANT_POS +: 2]);
    assign ovf = vtc_ovf_t'(ctrl_r[CTRL_OVF_POS +: 2]);
    assign in_sgn = ctrl_r[CTRL_INSGN_POS];
    assign out_sgn = ctrl_r[CTRL_OUTSGN_POS];

    // first half of the core: align binary point and quantise
    function automatic logic signed [WIDE_W-1:0] round_lane(
        input logic [IN_W-1:0] raw,
        input logic sgn,
        input vtc_quant_t q
    );
        logic signed [WIDE_W-1:0] v;
        logic signed [WIDE_W-1:0] keep;
        logic [WIDE_W-1:0] frac;
        logic inc;
        v = {{(WIDE_W-IN_W){raw[IN_W-1] & sgn}}, raw}; // [RQ17] [RQ1]
        v = v <<< GROW; // [RQ17] [RQ4]
        keep = v >>> DROP; // [RQ6] [RQ12]
        frac = v & DROP_MASK;
        inc = 1'b0;
        if (DROP > 0) begin
            case (q)
                VTC_Q_SYM: begin
                    inc = (frac > HALF_VAL) || (frac == HALF_VAL && !v[WIDE_W-1]); // [RQ7]
                end
                VTC_Q_CONV: begin
                    inc = (frac > HALF_VAL) || (frac == HALF_VAL && keep[0]); // [RQ8]
                end
                default: begin
                    inc = 1'b0; // [RQ6]
                end
            endcase
        end
        return keep + WIDE_W'(inc);
    endfunction

    // fixed to float, fraction truncated; small custom exponents may wrap
    function automatic logic [FP_W-1:0] float_lane(
        input logic [IN_W-1:0] raw,
        input logic sgn
    );
        logic neg;
        logic [IN_W-1:0] mag;
        logic [IN_W-1:0] norm;
        logic [FP_FRAC_W+IN_W-1:0] t;
        int p;
        neg = sgn && raw[IN_W-1];
        mag = neg ? IN_W'(-raw) : raw;
        p = 0;
        for (int i = 0; i < IN_W; i++) begin
            if (mag[i]) begin
                p = i;
            end
        end
        norm = mag << (IN_W - 1 - p);
        t = (FP_FRAC_W+IN_W)'(norm[IN_W-2:0]) << FP_FRAC_W;
        if (mag == '0) begin
            return {neg, {(FP_W-1){1'b0}}};
        end
        return {neg, FP_EXP_W'(FP_BIAS + p - IN_BP), t[FP_FRAC_W+IN_W-2 -: FP_FRAC_W]}; // [RQ5]
    endfunction

    // second half of the core: range handling and output format
    function automatic logic [LANE_OUT_W-1:0] finish_lane(
        input logic [IN_W-1:0] raw,
        input logic signed [WIDE_W-1:0] r,
        input vtc_out_t ot,
        input vtc_ovf_t ov,
        input logic isg,
        input logic osg
    );
        logic signed [WIDE_W-1:0] hi;
        logic signed [WIDE_W-1:0] lo;
        logic signed [WIDE_W-1:0] c;
        hi = osg ? (WIDE_W'(1) <<< (OUT_BITS - 1)) - WIDE_W'(1) :
                   (WIDE_W'(1) <<< OUT_BITS) - WIDE_W'(1);
        lo = osg ? -(WIDE_W'(1) <<< (OUT_BITS - 1)) : '0;
        c = r;
        if (ov == VTC_OV_SAT) begin
            if (r > hi) begin
                c = hi; // [RQ9]
            end else if (r < lo) begin
                c = lo; // [RQ9]
            end
        end
        // wrap and flag share the plain bit select below
        case (ot)
            VTC_OUT_BOOL: begin
                return LANE_OUT_W'(raw != '0); // [RQ3]
            end
            VTC_OUT_FLOAT: begin
                return LANE_OUT_W'(float_lane(raw, isg)); // [RQ3] [RQ5]
            end
            default: begin
                return LANE_OUT_W'(c[OUT_BITS-1:0]); // [RQ10] [RQ11] [RQ12] [RQ4]
            end
        endcase
    endfunction

    // the whole pipe stalls together, so stage data never needs skid storage
    assign adv = ce && en && fifo_wr_ready; // [RQ13]
    assign in_ready = adv;

    always_comb begin
        for (int l = 0; l < LANES_PER_PERIOD; l++) begin // [RQ2] [RQ1]
            rnd_comb[l*WIDE_W +: WIDE_W] = round_lane(in_data[l*IN_W +: IN_W], in_sgn, quant);
        end
    end

    generate
        if (MID_STAGE == 1) begin : g_mid
            logic [RAW_W-1:0] raw_r;
            logic [RND_W-1:0] rnd_r;
            logic vld_r;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    raw_r <= '0;
                    rnd_r <= '0;
                    vld_r <= 1'b0;
                end else if (adv) begin
                    raw_r <= in_data; // [RQ16]
                    rnd_r <= rnd_comb; // [RQ16]
                    vld_r <= in_valid;
                end
            end
            assign b_raw = raw_r;
            assign b_rnd = rnd_r;
            assign b_vld = vld_r;
        end else begin : g_nomid
            assign b_raw = in_data;
            assign b_rnd = rnd_comb;
            assign b_vld = in_valid;
        end
    endgenerate

    always_comb begin
        for (int l = 0; l < LANES_PER_PERIOD; l++) begin
            b_out[l*LANE_OUT_W +: LANE_OUT_W] = finish_lane(b_raw[l*IN_W +: IN_W],
                b_rnd[l*WIDE_W +: WIDE_W], out_type, ovf, in_sgn, out_sgn);
        end
    end

    generate
        if (NREG > 0) begin : g_regs
            logic [PKT_W-1:0] pd_r [NARR];
            logic [NARR-1:0] pv_r;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    for (int i = 0; i < NARR; i++) begin
                        pd_r[i] <= '0;
                    end
                    pv_r <= '0;
                end else if (adv) begin
                    pd_r[0] <= b_out; // [RQ15] [RQ16]
                    pv_r[0] <= b_vld;
                    for (int i = 1; i < NARR; i++) begin
                        pd_r[i] <= pd_r[i-1]; // [RQ14] [RQ15]
                        pv_r[i] <= pv_r[i-1];
                    end
                end
            end
            assign fifo_wr_data = pd_r[NARR-1];
            assign fifo_wr_valid = pv_r[NARR-1] && ce && en;
            assign busy = (|pv_r) || b_vld && (MID_STAGE == 1);
        end else begin : g_wire
            assign fifo_wr_data = b_out; // [RQ14]
            assign fifo_wr_valid = in_valid && ce && en;
            assign busy = 1'b0;
        end
    endgenerate

    vtc_fifo #(
        .W(PKT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .wr_valid(fifo_wr_valid),
        .wr_ready(fifo_wr_ready),
        .wr_data(fifo_wr_data),
        .rd_valid(out_valid),
        .rd_ready(out_ready),
        .rd_data(out_data),
        .level(fifo_level)
    );

    // axi4-lite slave, one write and one read at a time
    logic aw_got_r;
    logic w_got_r;
    logic [5:0] aw_idx_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    assign s_axi_awready = ce && !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = ce && !w_got_r && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_idx_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_idx_r <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (aw_got_r && w_got_r) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_idx_r <= CONFIG_IDX) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (ce && aw_got_r && w_got_r && aw_idx_r == CTRL_IDX && wstrb_r[0]) begin
            ctrl_r <= wdata_r[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= '0;
                case (s_axi_araddr[7:2])
                    CTRL_IDX: begin
                        s_axi_rdata <= {24'h000000, ctrl_r};
                    end
                    STATUS_IDX: begin
                        s_axi_rdata[ST_LVL_POS +: LVL_W] <= fifo_level;
                        s_axi_rdata[ST_FULL_POS] <= !fifo_wr_ready;
                        s_axi_rdata[ST_EMPTY_POS] <= !out_valid;
                        s_axi_rdata[ST_EN_POS] <= en;
                        s_axi_rdata[ST_BUSY_POS] <= busy;
                    end
                    CONFIG_IDX: begin
                        s_axi_rdata[7:0] <= 8'(LANES_PER_PERIOD);
                        s_axi_rdata[CFG_LAT_POS +: 8] <= 8'(LATENCY);
                        s_axi_rdata[CFG_PIPE_POS] <= PIPE_MAX;
                        s_axi_rdata[CFG_FP_POS +: 2] <= 2'(FP_SEL);
                    end
                    default: begin
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ---- testbench/vtc_properties.sv ----
// concurrent checks on the converter's top-level ports
`timescale 1ns/100ps
module vtc_properties import vtc_pkg::*; (
    // clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic en,
    // stream
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [LANES_PER_PERIOD*LANE_OUT_W-1:0] out_data,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    freeze_gate_a: assert property (in_ready |-> ce && en)
        else $error("sample accepted while frozen");
    ce_hold_a: assert property (!ce |-> !out_valid && !s_axi_awready && !s_axi_arready)
        else $error("outputs offered with clock enable low");
    pipe_delay_a: assert property (in_valid && in_ready ##1 in_ready [*3] |=> out_valid || !ce)
        else $error("vector missing after three advances");
    out_stand_a: assert property (out_valid && !out_ready ##1 ce |-> out_valid && $stable(out_data))
        else $error("output changed before it was taken");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        ##1 ce |=> s_axi_bvalid)
        else $error("write response late");
    b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response changed before taken");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while a read is pending");
    bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > CONFIG_IDX
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

// ---- testbench/vtc_sink.sv ----
// downstream consumer model with selectable back-pressure
`timescale 1ns/100ps
module vtc_sink (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // 0 always ready, 1 stalled, 2 every other offered cycle
    input wire logic [1:0] mode,
    // stream
    input wire logic out_valid,
    output logic out_ready
);
    logic phase_r;
    // phase only moves while data is offered, so stalls hit real transfers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 1'h0;
        end else if (out_valid) begin
            phase_r <= !phase_r;
        end
    end
    // whole vector taken at once, lanes never split
    assign out_ready = (mode == 2'h0) || (mode == 2'h2 && phase_r);
endmodule

// ---- testbench/tb_vector_type_converter.sv ----
// self-checking bench of the vector type converter
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_vector_type_converter import vtc_pkg::*;;
    typedef struct packed {logic [7:0] c; logic [15:0] x; logic [31:0] y;} vtc_row_t;
    localparam vtc_row_t ROWS [0:20] = '{
        '{8'hC1, 16'h0128, 32'h12}, '{8'hC1, 16'hFEF8, 32'hFEF},
        '{8'hC5, 16'h0118, 32'h12}, '{8'hC5, 16'hFEE8, 32'hFEE},
        '{8'hC9, 16'h0128, 32'h12}, '{8'hC9, 16'h0138, 32'h14},
        '{8'hCD, 16'h0118, 32'h11}, '{8'hC5, 16'h7FF8, 32'h7FF},
        '{8'hD5, 16'h7FF8, 32'h800}, '{8'hE5, 16'h7FF8, 32'h800},
        '{8'hF5, 16'h7FF8, 32'h800}, '{8'h41, 16'hFEE8, 32'h0},
        '{8'h51, 16'hFEE8, 32'hFEE}, '{8'h05, 16'hFFF8, 32'hFFF},
        '{8'h81, 16'h8000, 32'h7FF}, '{8'h91, 16'h8000, 32'h800},
        '{8'hC3, 16'h0128, 32'h12}, '{8'hC0, 16'hFF00, 32'h1},
        '{8'hC2, 16'h0100, 32'h3F800000}, '{8'hC2, 16'hFF00, 32'hBF800000},
        '{8'h02, 16'hFF00, 32'h437F0000}};
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic ce = 1'h1;
    logic en = 1'h1;
    logic in_valid = 1'h0;
    logic [63:0] in_data = '0;
    logic [1:0] mode = 2'h0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rd;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic in_ready, out_valid, out_ready, awready, wready, bvalid, arready, rvalid;
    logic [127:0] out_data, o;
    logic [127:0] got [$];
    logic [31:0] rdata;
    logic [1:0] bresp, rresp, rs;
    int error_cnt = 0, checks = 0, cyc = 0, n;

    vtc_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .en(en), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    vtc_sink i_sink (.aclk(aclk), .aresetn(aresetn), .mode(mode), .out_valid(out_valid),
        .out_ready(out_ready));

    always #5 aclk = ~aclk;
    // mid-cycle capture avoids racing the checks made at the rising edge
    always @(negedge aclk) if (aresetn && out_valid && out_ready) got.push_back(out_data);
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        rs = bresp;
    endtask
    task automatic axi_rd(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        rd = rdata;
        rs = rresp;
    endtask
    // leaves in_valid high so back-to-back calls keep streaming
    task automatic send(input logic [63:0] d);
        in_data <= d;
        in_valid <= 1'h1;
        do @(posedge aclk); while (!in_ready);
    endtask
    task automatic wait_out(input int lat);
        n = 0;
        while (got.size() == 0 && n < 50) begin
            @(posedge aclk);
            n++;
        end
        `CHK("latency", lat, n)
        o = got.pop_front();
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(32'h0);
        `CHK("ctrl reset", 32'hC1, rd)
        foreach (ROWS[i]) begin
            axi_wr(32'h0, {24'h0, ROWS[i].c});
            `CHK("ctrl write", RESP_OKAY, rs)
            send(64'(ROWS[i].x) << (16 * (i % 4)));
            in_valid <= 1'h0;
            wait_out(LATENCY + 1);
            `CHK("lanes", 128'(ROWS[i].y) << (32 * (i % 4)), o)
        end
        axi_wr(32'h0, 32'hC1);
        send(64'h10);
        in_valid <= 1'h0;
        en <= 1'h0;
        repeat (10) @(posedge aclk);
        `CHK("frozen", 0, got.size())
        en <= 1'h1;
        wait_out(LATENCY + 1);
        `CHK("thawed", 128'h1, o)
        mode <= 2'h1;
        for (int i = 0; i < 19; i++) send(64'(i * 16));
        in_valid <= 1'h0;
        axi_rd(32'h4);
        `CHK("status full", 32'hD10, rd)
        `CHK("refused", 1'h0, in_ready)
        ce <= 1'h0;
        @(posedge aclk);
        `CHK("ce gate", 1'h0, out_valid)
        ce <= 1'h1;
        mode <= 2'h2;
        n = 0;
        while (got.size() < 19 && n < 300) begin
            @(posedge aclk);
            n++;
        end
        for (int i = 0; i < 19; i++) begin
            o = got.pop_front();
            `CHK("order", 128'(i), o)
        end
        mode <= 2'h0;
        axi_rd(32'h4);
        `CHK("status empty", 32'h600, rd)
        axi_rd(32'h8);
        `CHK("config", 32'h00010304, rd)
        axi_rd(32'hC);
        `CHK("bad read", {RESP_SLVERR, 32'h0}, {rs, rd})
        axi_wr(32'h10, 32'h0);
        `CHK("bad write", RESP_SLVERR, rs)
        axi_wr(32'h4, 32'hFFF);
        `CHK("ro write", RESP_OKAY, rs)
        axi_wr(32'h0, 32'h55);
        send(64'h10);
        in_valid <= 1'h0;
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (8) @(posedge aclk);
        `CHK("reset flush", 0, got.size())
        axi_rd(32'h0);
        `CHK("ctrl re-reset", 32'hC1, rd)
        stop_test();
    end
endmodule

bind vtc_top vtc_properties i_props (.*);
